// *** design/ubsm_pkg.sv ***
// Functional notes
// RULE_01 - either clock select makes timer two baud source
// RULE_02 - uart1 selects in timer control, uart2 in power
// RULE_03 - high byte overflow reloads both count bytes
// RULE_04 - baud equals overflow rate over sixteen
// RULE_05 - timer baud is fosc over 32 times range
// RULE_06 - baud overflow never sets overflow flag
// RULE_07 - trigger edge sets flag, never reloads
// RULE_08 - software stops timer before count or reload access
// RULE_09 - mode 0 data on rxd, clock on txd
// RULE_10 - mode 0 bit rate is fosc over twelve
// RULE_11 - buffer write loads marker, send one cycle later
// RULE_12 - send drives rxd, clock low s3 to s5
// RULE_13 - transmit shifts right at s6p2, zero fill
// RULE_14 - send ends, flag set at tenth cycle s1p1
// RULE_15 - receive starts when enabled and flag clear
// RULE_16 - receive clock toggles s3p1 and s6p1, shift left
// RULE_17 - entering bit sampled at s5p2 same cycle
// RULE_18 - receive ends, buffer loads, flag set tenth cycle
// RULE_19 - done flags set by hardware, cleared by software
// RULE_20 - machine cycle is twelve phases s1 to s6
// RULE_21 - baud timer counts every two oscillator periods
package ubsm_pkg;
  // register indices on the plain port
  localparam logic [3:0] ADDR_SERIAL_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SERIAL_BUFFER  = 4'h1;
  localparam logic [3:0] ADDR_TIMER_CONTROL  = 4'h2;
  localparam logic [3:0] ADDR_POWER_CONTROL  = 4'h3;
  localparam logic [3:0] ADDR_COUNT_LOW      = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HIGH     = 4'h5;
  localparam logic [3:0] ADDR_RELOAD_LOW     = 4'h6;
  localparam logic [3:0] ADDR_RELOAD_HIGH    = 4'h7;
  localparam logic [3:0] ADDR_BAUD_STATUS    = 4'h8;
  // serial control fields
  localparam int SC_RX_ENABLE = 4;
  localparam int SC_TX_DONE   = 1;
  localparam int SC_RX_DONE   = 0;
  // timer control fields
  localparam int TC_OVERFLOW  = 7;
  localparam int TC_EXT_FLAG  = 6;
  localparam int TC_RX_CLK    = 5;
  localparam int TC_TX_CLK    = 4;
  localparam int TC_EXT_EN    = 3;
  localparam int TC_RUN       = 2;
  localparam int TC_CNT_SEL   = 1;
  // power control fields for the second uart
  localparam int PC_RX_CLK    = 5;
  localparam int PC_TX_CLK    = 4;
  // machine cycle timing
  localparam int          OSC_PER_PHASE = 1;
  localparam logic [3:0]  PHASES_PER_MC = 4'hC;
  localparam logic [3:0]  PH_S1P1 = 4'h0;
  localparam logic [3:0]  PH_S3P1 = 4'h4;
  localparam logic [3:0]  PH_S5P2 = 4'h9;
  localparam logic [3:0]  PH_S6P1 = 4'hA;
  localparam logic [3:0]  PH_S6P2 = 4'hB;
  localparam int          BAUD_DIV_OSC  = 2;
  localparam logic [3:0]  BAUD_OVF_DIV  = 4'hF;
  localparam logic [3:0]  MODE0_CYCLES  = 4'hA;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [8:0]  RX_PRELOAD    = 9'h1FE;
endpackage

// *** design/ubsm_timer_if.sv ***
// baud timer view shared between the core and the timer module
interface ubsm_timer_if;
  logic [7:0] reload_lo;
  logic [7:0] reload_hi;
  logic       run;
  logic       cnt_sel;
  logic       baud_mode;
  logic       ext_tick;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wdata;
  logic [15:0] count;
  logic       overflow;
  logic       overflow_raw;
  modport core  (output reload_lo, reload_hi, run, cnt_sel, baud_mode, ext_tick, wr_lo, wr_hi, wdata,
                 input count, overflow, overflow_raw);
  modport timer (input reload_lo, reload_hi, run, cnt_sel, baud_mode, ext_tick, wr_lo, wr_hi, wdata,
                 output count, overflow, overflow_raw);
endinterface

// *** design/ubsm_baud_timer.sv ***
module ubsm_baud_timer
  import ubsm_pkg::*;
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_b,
  // register side
  ubsm_timer_if.timer tif
);
  logic        half_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        ovf_q;
  logic        ovf_raw_q;
  wire         tick     = tif.cnt_sel ? tif.ext_tick : half_q;  // RULE_21
  wire         step     = tif.run && tick;
  wire         roll     = step && (cnt_q == 16'hFFFF);
  wire [15:0]  reload_v = {tif.reload_hi, tif.reload_lo};

  // count and reload; writes while running are software's hazard
  always_comb begin
    cnt_d = cnt_q;
    if (tif.wr_lo) cnt_d = {cnt_q[15:8], tif.wdata};
    else if (tif.wr_hi) cnt_d = {tif.wdata, cnt_q[7:0]};
    else if (roll) cnt_d = reload_v;  // RULE_03
    else if (step) cnt_d = cnt_q + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= 1'b0;
      cnt_q  <= 16'h0000;
      ovf_q  <= 1'b0;
      ovf_raw_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      cnt_q  <= cnt_d;
      ovf_q  <= roll && tif.baud_mode;
      ovf_raw_q <= roll;  // every roll; the core drops it in baud mode
    end
  end

  assign tif.count    = cnt_q;
  assign tif.overflow = ovf_q;
  assign tif.overflow_raw = ovf_raw_q;

  reload_on_roll_a: assert property (@(posedge clk) disable iff (!rst_b)  // RULE_03
    (roll && !tif.wr_lo && !tif.wr_hi) |=> cnt_q == $past(reload_v))
    else $error("roll did not reload count");
  timer_half_rate_a: assert property (@(posedge clk) disable iff (!rst_b)  // RULE_21
    (tif.run && !tif.cnt_sel && step) |=> !step)
    else $error("timer stepped on two adjacent clocks");
endmodule

// *** design/ubsm_core.sv ***
module ubsm_core
  import ubsm_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  // register port
  input  wire logic [3:0]        ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic      [DATA_W-1:0] RDATA,
  // timer trigger pins
  input  wire logic              EXTERNAL_TRIGGER_PIN,
  input  wire logic              TIMER_COUNT_PIN,
  // mode 0 pins: rxd bidirectional, txd shift clock
  input  wire logic              RXD_IN,
  output logic                   RXD_OUT,
  output logic                   RXD_OE,
  output logic                   TXD_OUT,
  // baud ticks for the asynchronous modes
  output logic                   UART1_TX_BAUD_TICK,
  output logic                   UART1_RX_BAUD_TICK,
  output logic                   UART2_TX_BAUD_TICK,
  output logic                   UART2_RX_BAUD_TICK
);
  typedef enum logic [2:0] {
    UBSM_IDLE = 3'b001,
    UBSM_WAIT = 3'b010,
    UBSM_RUN  = 3'b100
  } ubsm_seq_t;

  // reset release through two flops
  logic rst_s1_q;
  logic rst_q;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end
  wire rst_b = rst_q;

  // registers
  logic [7:0] serial_control_reg_q;
  logic [7:0] serial_buffer_q;
  logic [7:0] timer_two_control_reg_q;
  logic [7:0] power_control_reg_q;
  logic [7:0] rlo_q;
  logic [7:0] rhi_q;
  logic [3:0] phase_q;
  logic       trig_q;
  logic       cnt_pin_q;
  logic [3:0] ovf_div_q;
  ubsm_timer_if tif ();

  // decode
  wire wr_serial_control_reg  = WR_STB && (ADDR == ADDR_SERIAL_CONTROL);
  wire wr_serial_buffer  = WR_STB && (ADDR == ADDR_SERIAL_BUFFER);
  wire wr_timer_two_control_reg = WR_STB && (ADDR == ADDR_TIMER_CONTROL);
  wire wr_power_control_reg  = WR_STB && (ADDR == ADDR_POWER_CONTROL);
  wire wr_rlo   = WR_STB && (ADDR == ADDR_RELOAD_LOW);
  wire wr_rhi   = WR_STB && (ADDR == ADDR_RELOAD_HIGH);
  wire uart1_sel = timer_two_control_reg_q[TC_RX_CLK] | timer_two_control_reg_q[TC_TX_CLK];  // RULE_02
  wire uart2_sel = power_control_reg_q[PC_RX_CLK] | power_control_reg_q[PC_TX_CLK];  // RULE_02
  wire baud_mode = uart1_sel | uart2_sel;  // RULE_01
  wire trig_fall = trig_q && !EXTERNAL_TRIGGER_PIN;
  wire cnt_fall  = cnt_pin_q && !TIMER_COUNT_PIN;
  wire ext_set   = baud_mode && timer_two_control_reg_q[TC_EXT_EN] && trig_fall;  // RULE_07
  // overflow outside baud mode, set flag; baud mode leaves it alone
  wire ovf_set   = tif.overflow_raw && !baud_mode;  // RULE_06

  function automatic logic at_phase(input logic [3:0] ph, input logic [3:0] want);
    return ph == want;
  endfunction

  // first bit in lands at bit 7 after the left shifts; turn the byte round so it reads lsb first
  function automatic logic [7:0] rev_byte(input logic [7:0] b);
    return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction

  // machine cycle phase counter: twelve phases
  wire mc_end = at_phase(phase_q, PHASES_PER_MC - 4'h1);  // RULE_10 RULE_20
  always_ff @(posedge CORE_CLK or negedge rst_b) begin
    if (!rst_b) phase_q <= 4'h0;
    else phase_q <= mc_end ? 4'h0 : phase_q + 4'h1;
  end
  wire p_s1p1 = at_phase(phase_q, PH_S1P1);
  wire p_s3p1 = at_phase(phase_q, PH_S3P1);
  wire p_s5p2 = at_phase(phase_q, PH_S5P2);
  wire p_s6p1 = at_phase(phase_q, PH_S6P1);
  wire p_s6p2 = at_phase(phase_q, PH_S6P2);

  // timer wiring
  assign tif.reload_lo = rlo_q;
  assign tif.reload_hi = rhi_q;
  assign tif.run       = timer_two_control_reg_q[TC_RUN];
  assign tif.cnt_sel   = timer_two_control_reg_q[TC_CNT_SEL];
  assign tif.baud_mode = baud_mode;
  assign tif.ext_tick  = cnt_fall;
  assign tif.wr_lo     = WR_STB && (ADDR == ADDR_COUNT_LOW);
  assign tif.wr_hi     = WR_STB && (ADDR == ADDR_COUNT_HIGH);
  assign tif.wdata     = WDATA;
  ubsm_baud_timer u_timer (
    .clk   (CORE_CLK),
    .rst_b (rst_b),
    .tif   (tif)
  );
  wire baud_ovf = tif.overflow;

  // mode 0 transmitter
  ubsm_seq_t  tx_st_q;
  logic [8:0] tx_sr_q;
  logic [3:0] tx_mc_q;
  logic       tx_done_set;
  wire        tx_send  = (tx_st_q == UBSM_RUN);
  wire        tx_last  = (tx_sr_q[8:1] == 8'h01);  // RULE_14
  assign tx_done_set = tx_send && p_s1p1 && (tx_mc_q == MODE0_CYCLES);  // RULE_14
  always_ff @(posedge CORE_CLK or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_q <= UBSM_IDLE;
      tx_sr_q <= 9'h000;
      tx_mc_q <= 4'h0;
    end else if (wr_serial_buffer) begin
      tx_st_q <= UBSM_WAIT;
      tx_sr_q <= {1'b1, WDATA};  // RULE_11
      tx_mc_q <= 4'h0;
    end else begin
      if (tx_st_q != UBSM_IDLE && mc_end) tx_mc_q <= tx_mc_q + 4'h1;
      unique case (tx_st_q)
        UBSM_IDLE: tx_st_q <= UBSM_IDLE;
        UBSM_WAIT: if (mc_end && tx_mc_q == 4'h1) tx_st_q <= UBSM_RUN;  // RULE_11
        UBSM_RUN: begin
          if (p_s6p2) tx_sr_q <= {1'b0, tx_sr_q[8:1]};  // RULE_13
          if (tx_done_set) tx_st_q <= UBSM_IDLE;
        end
      endcase
    end
  end

  // mode 0 receiver
  ubsm_seq_t  rx_st_q;
  logic [8:0] rx_sr_q;
  logic [3:0] rx_mc_q;
  logic       rx_bit_q;
  logic       rx_done_set;
  wire [7:0]  rx_byte  = rev_byte(rx_sr_q[7:0]);  // RULE_09
  wire        rx_recv  = (rx_st_q == UBSM_RUN);
  wire        rx_start = serial_control_reg_q[SC_RX_ENABLE] && !serial_control_reg_q[SC_RX_DONE] && !wr_serial_control_reg;  // RULE_15
  assign rx_done_set = rx_recv && p_s1p1 && (rx_mc_q == MODE0_CYCLES);  // RULE_18
  always_ff @(posedge CORE_CLK or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q  <= UBSM_IDLE;
      rx_sr_q  <= 9'h1FF;
      rx_mc_q  <= 4'h0;
      rx_bit_q <= 1'b0;
    end else begin
      if (rx_st_q != UBSM_IDLE && mc_end) rx_mc_q <= rx_mc_q + 4'h1;
      if (p_s5p2) rx_bit_q <= RXD_IN;  // RULE_17
      unique case (rx_st_q)
        UBSM_IDLE: if (rx_start) begin
          rx_st_q <= UBSM_WAIT;
          rx_mc_q <= 4'h0;
        end
        UBSM_WAIT: if (p_s6p2 && rx_mc_q == 4'h1) begin
          rx_sr_q <= RX_PRELOAD;  // RULE_15
          rx_st_q <= UBSM_RUN;
        end
        UBSM_RUN: begin
          if (p_s6p2 && rx_sr_q[8]) rx_sr_q <= {rx_sr_q[7:0], rx_bit_q};  // RULE_16
          if (rx_done_set) rx_st_q <= UBSM_IDLE;  // RULE_18
        end
      endcase
    end
  end

  // registers: hardware set wins over software clear
  always_ff @(posedge CORE_CLK or negedge rst_b) begin
    if (!rst_b) begin
      serial_control_reg_q  <= REG_RESET;
      serial_buffer_q  <= REG_RESET;
      timer_two_control_reg_q <= REG_RESET;
      power_control_reg_q  <= REG_RESET;
      rlo_q   <= REG_RESET;
      rhi_q   <= REG_RESET;
    end else begin
      if (wr_serial_control_reg) serial_control_reg_q <= WDATA;
      if (tx_done_set) serial_control_reg_q[SC_TX_DONE] <= 1'b1;  // RULE_19
      if (rx_done_set) serial_control_reg_q[SC_RX_DONE] <= 1'b1;  // RULE_19
      if (rx_done_set) serial_buffer_q <= rx_byte;  // RULE_18
      if (wr_timer_two_control_reg) timer_two_control_reg_q <= WDATA;
      if (ovf_set) timer_two_control_reg_q[TC_OVERFLOW] <= 1'b1;  // RULE_06
      if (ext_set) timer_two_control_reg_q[TC_EXT_FLAG] <= 1'b1;  // RULE_07
      if (wr_power_control_reg) power_control_reg_q <= WDATA;
      if (wr_rlo) rlo_q <= WDATA;
      if (wr_rhi) rhi_q <= WDATA;
    end
  end

  // read mux, answered one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (ADDR)
      ADDR_SERIAL_CONTROL: rd_mux = serial_control_reg_q;
      ADDR_SERIAL_BUFFER:  rd_mux = serial_buffer_q;
      ADDR_TIMER_CONTROL:  rd_mux = timer_two_control_reg_q;
      ADDR_POWER_CONTROL:  rd_mux = power_control_reg_q;
      ADDR_COUNT_LOW:      rd_mux = tif.count[7:0];
      ADDR_COUNT_HIGH:     rd_mux = tif.count[15:8];
      ADDR_RELOAD_LOW:     rd_mux = rlo_q;
      ADDR_RELOAD_HIGH:    rd_mux = rhi_q;
      ADDR_BAUD_STATUS:    rd_mux = {4'h0, ovf_div_q};
      default:             rd_mux = 8'h00;
    endcase
  end

  // shift clock and pin drive; clock high s6 to s2, low s3 to s5
  wire sclk_low = (phase_q >= PH_S3P1) && (phase_q < PH_S6P1);  // RULE_12
  always_ff @(posedge CORE_CLK or negedge rst_b) begin
    if (!rst_b) begin
      RDATA     <= 8'h00;
      RXD_OUT   <= 1'b1;
      RXD_OE    <= 1'b0;
      TXD_OUT   <= 1'b1;
      trig_q    <= 1'b1;
      cnt_pin_q <= 1'b1;
      ovf_div_q <= 4'h0;
      UART1_TX_BAUD_TICK <= 1'b0;
      UART1_RX_BAUD_TICK <= 1'b0;
      UART2_TX_BAUD_TICK <= 1'b0;
      UART2_RX_BAUD_TICK <= 1'b0;
    end else begin
      RDATA     <= RD_STB ? rd_mux : 8'h00;
      RXD_OUT   <= tx_send ? tx_sr_q[0] : 1'b1;  // RULE_12
      RXD_OE    <= tx_send;  // RULE_09
      TXD_OUT   <= (tx_send || rx_recv) ? !sclk_low : 1'b1;  // RULE_16
      trig_q    <= EXTERNAL_TRIGGER_PIN;
      cnt_pin_q <= TIMER_COUNT_PIN;
      if (baud_ovf) ovf_div_q <= ovf_div_q + 4'h1;
      // one tick per sixteen overflows
      UART1_TX_BAUD_TICK <= baud_ovf && ovf_div_q == BAUD_OVF_DIV && timer_two_control_reg_q[TC_TX_CLK];  // RULE_04
      UART1_RX_BAUD_TICK <= baud_ovf && ovf_div_q == BAUD_OVF_DIV && timer_two_control_reg_q[TC_RX_CLK];  // RULE_04
      UART2_TX_BAUD_TICK <= baud_ovf && ovf_div_q == BAUD_OVF_DIV && power_control_reg_q[PC_TX_CLK];  // RULE_05
      UART2_RX_BAUD_TICK <= baud_ovf && ovf_div_q == BAUD_OVF_DIV && power_control_reg_q[PC_RX_CLK];  // RULE_05
    end
  end

  tx_lsb_first_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_13
    (tx_send && p_s6p2 && !wr_serial_buffer) |=> tx_sr_q == {1'b0, $past(tx_sr_q[8:1])})
    else $error("transmit shift not right with zero fill");
  tx_done_time_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_14
    (tx_done_set && !wr_serial_buffer) |=> !tx_send && serial_control_reg_q[SC_TX_DONE])
    else $error("send not ended with flag");
  tx_marker_last_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_14
    tx_done_set |-> tx_sr_q[8:1] == 8'h00)
    else $error("marker not consumed at end of send");
  rx_sample_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_17
    p_s5p2 |=> rx_bit_q == $past(RXD_IN))
    else $error("receive sample missed");
  sclk_shape_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_12
    (tx_send && p_s3p1 && !wr_serial_buffer) |=> !TXD_OUT [*3])
    else $error("shift clock not low after s3");
  no_ovf_flag_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_06
    (baud_mode && !wr_timer_two_control_reg && !timer_two_control_reg_q[TC_OVERFLOW]) |=> !timer_two_control_reg_q[TC_OVERFLOW])
    else $error("overflow flag set in baud mode");
  rx_flag_load_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_18
    rx_done_set |=> serial_control_reg_q[SC_RX_DONE] && serial_buffer_q == $past(rx_byte))
    else $error("receive completion missing");
  mc_wrap_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_20
    mc_end |=> phase_q == 4'h0)
    else $error("machine cycle not twelve phases");

  // mode 0 sequencing, timer flag and tick checks
  tx_marker_left_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_14
    (tx_send && p_s1p1 && tx_mc_q == MODE0_CYCLES - 4'h1) |-> tx_last)
    else $error("marker not beside msb before last shift");
  tx_wait_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_11
    wr_serial_buffer |=> !tx_send [*8])
    else $error("send began too soon after buffer write");
  sclk_high_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_12
    (tx_send && p_s6p1) |=> TXD_OUT)
    else $error("shift clock not high at s6");
  rx_preload_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_15
    (rx_st_q == UBSM_WAIT && p_s6p2 && rx_mc_q == 4'h1) |=> rx_recv && rx_sr_q == RX_PRELOAD)
    else $error("receive preload or start missed");
  rx_flag_hold_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_15
    (rx_st_q == UBSM_IDLE && serial_control_reg_q[SC_RX_DONE]) |=> rx_st_q == UBSM_IDLE)
    else $error("receive started with flag set");
  rx_left_shift_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_16
    (rx_recv && p_s6p2 && rx_sr_q[8]) |=> rx_sr_q == {$past(rx_sr_q[7:0]), $past(rx_bit_q)})
    else $error("receive shift not left with sampled bit");
  baud_tick_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_04
    (UART1_TX_BAUD_TICK || UART1_RX_BAUD_TICK || UART2_TX_BAUD_TICK || UART2_RX_BAUD_TICK)
    |-> ovf_div_q == 4'h0)
    else $error("baud tick not on sixteenth overflow");
  ovf_flag_set_a: assert property (@(posedge CORE_CLK) disable iff (!rst_b)  // RULE_06
    (ovf_set && !wr_timer_two_control_reg) |=> timer_two_control_reg_q[TC_OVERFLOW])
    else $error("overflow flag missed outside baud mode");
endmodule

// *** tb/ubsm_shift_partner.sv ***
// external shift register on the mode 0 pins: captures what the device sends
// and serves a byte back when the device receives
module ubsm_shift_partner (
  // shift clock from the device and the resolved data line
  input  wire logic       shift_clk,
  input  wire logic       line,
  input  wire logic       dev_oe,
  // byte to hand back, byte captured
  input  wire logic [7:0] send_byte,
  output logic            drv_val,
  output logic            drv_en,
  output logic [7:0]      got_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] bit_q = 3'h0;
  logic       en_q  = 1'b0;
  logic       val_q = 1'b1;
  logic [7:0] got_q = 8'h00;
  assign drv_en   = en_q;
  assign drv_val  = val_q;
  assign got_byte = got_q;
  // one process for both edges so each variable has one writer; the clock's
  // unknown-to-high step at reset finds en_q low and so counts no bit
  always @(shift_clk) begin
    if (shift_clk === 1'b1) begin
      // rising clock marks a stable data bit; lsb comes first so it ends up at bit 0
      if (dev_oe) got_q <= {line, got_q[7:1]};
      if (en_q) begin
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) en_q <= 1'b0; // line released after the eighth sample
      end
    end else if (shift_clk === 1'b0 && !dev_oe) begin
      // change data on the falling clock, well ahead of the device sample point
      en_q  <= 1'b1;
      val_q <= send_byte[bit_q];
    end
  end
endmodule

// *** tb/tb.sv ***
module tb
  import ubsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LO = 108;
  localparam int HI = 136;
  logic       clk, rst_b, wr_stb, rd_stb, ext_pin, cnt_pin, txd_q;
  logic [3:0] addr;
  logic [7:0] wdata, p_send, d;
  wire logic [7:0] rdata, p_got;
  wire logic [3:0] tick;
  wire logic  rxd, rxd_out, rxd_oe, txd, p_val, p_en;
  int cyc, nrise, per, rise_at, n_mismatch, n_compared, i;
  // rxd has a pull-up, so a released line reads high
  assign rxd = rxd_oe ? rxd_out : (p_en ? p_val : 1'b1);
  ubsm_core i_dut (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .EXTERNAL_TRIGGER_PIN(ext_pin), .TIMER_COUNT_PIN(cnt_pin),
    .RXD_IN(rxd), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .TXD_OUT(txd),
    .UART1_TX_BAUD_TICK(tick[0]), .UART1_RX_BAUD_TICK(tick[1]),
    .UART2_TX_BAUD_TICK(tick[2]), .UART2_RX_BAUD_TICK(tick[3]));
  ubsm_shift_partner i_peer (.shift_clk(txd), .line(rxd), .dev_oe(rxd_oe), .send_byte(p_send),
    .drv_val(p_val), .drv_en(p_en), .got_byte(p_got));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cycle count, shift clock rise tracking, and the hang limit
  always @(posedge clk) begin
    cyc   <= cyc + 1;
    txd_q <= txd;
    if (txd === 1'b1 && txd_q === 1'b0) begin
      per     <= cyc - rise_at;
      rise_at <= cyc;
      nrise   <= nrise + 1;
    end
    if (cyc > 60000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic poll(input int b, input int t0);
    logic [7:0] v;
    for (int k = 0; k < 200; k++) begin
      rd(ADDR_SERIAL_CONTROL, v);
      if (v[b] === 1'b1) break;
    end
    chk((cyc - t0) >= LO && (cyc - t0) <= HI, 32'h1);
  endtask
  // timer stopped before the count and reload bytes are touched
  task automatic baud(input int k, input logic [15:0] r);
    int gap;
    logic [3:0] seen;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, r[7:0]);
    wr(ADDR_COUNT_HIGH, r[15:8]);
    wr(ADDR_RELOAD_LOW, r[7:0]);
    wr(ADDR_RELOAD_HIGH, r[15:8]);
    rd(ADDR_RELOAD_HIGH, d);
    chk(d, r[15:8]);
    wr(ADDR_POWER_CONTROL, (k == 2) ? 8'h10 : (k == 3) ? 8'h20 : 8'h00);
    wr(ADDR_TIMER_CONTROL, (k == 0) ? 8'h1C : (k == 1) ? 8'h2C : 8'h0C);
    for (int j = 0; j < 400 && tick[k] !== 1'b1; j++) begin
      @(posedge clk);
      #1;
    end
    seen = 4'h0;
    // a trigger edge inside the measured interval must not disturb it
    for (gap = 1; gap < 5000; gap++) begin
      @(posedge clk);
      if (gap == 10) ext_pin <= 1'b0;
      #1 seen = seen | tick;
      if (tick[k] === 1'b1) break;
    end
    chk(gap, 32'h20 * (32'h10000 - r));
    chk(seen, 4'h1 << k);
    rd(ADDR_TIMER_CONTROL, d);
    chk(d[7:6], 2'b01);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'h00);
    ext_pin <= 1'b1;
  endtask
  task automatic tx(input logic [7:0] b);
    int n0;
    n0 = nrise;
    wr(ADDR_SERIAL_BUFFER, b);
    poll(SC_TX_DONE, cyc);
    chk(p_got, b);
    chk(nrise - n0, 32'h8);
    chk(per, 32'hC);
    chk(rxd_oe, 1'b0);
    wr(ADDR_SERIAL_CONTROL, 8'h00);
  endtask
  task automatic rx(input logic [7:0] b);
    int n0;
    p_send = b;
    wr(ADDR_SERIAL_CONTROL, 8'h10);
    poll(SC_RX_DONE, cyc);
    rd(ADDR_SERIAL_BUFFER, d);
    chk(d, b);
    n0 = nrise;
    repeat (40) @(posedge clk);
    chk(nrise - n0, 32'h0);
    wr(ADDR_SERIAL_CONTROL, 8'h00);
  endtask
  initial begin
    rst_b = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ext_pin = 1'b1;
    cnt_pin = 1'b1;
    p_send = 8'h00;
    txd_q = 1'b1;
    {cyc, nrise, per, rise_at, n_mismatch, n_compared} = '0;
    void'($urandom(113));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // every index, mapped or not, reads zero after reset
    for (i = 0; i < 16; i++) begin
      rd(i[3:0], d);
      chk(d, REG_RESET);
    end
    wr(4'hC, 8'hFF);
    rd(4'hC, d);
    chk(d, 8'h00);
    for (i = 0; i < 4; i++) baud(i, 16'hFFFF - 16'($urandom_range(3)));
    // counter mode outside baud mode: no pin edge, no step; one edge rolls and sets the flag
    wr(ADDR_COUNT_LOW, 8'hFF);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_TIMER_CONTROL, 8'h06);
    repeat (6) @(posedge clk);
    rd(ADDR_TIMER_CONTROL, d);
    chk(d[7], 1'b0);
    cnt_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ADDR_TIMER_CONTROL, d);
    chk(d[7], 1'b1);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    cnt_pin <= 1'b1;
    tx(8'hFF);
    tx(8'h01);
    tx(8'($urandom));
    rx(8'h80);
    rx(8'h00);
    rx(8'($urandom));
    summarize();
  end
endmodule
